// file: shared/ocp_pkg.sv
package ocp_pkg;
  localparam int CNT_W = 16;
  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int STAT_W = 2;
  localparam int MODE_W = 3;
  localparam int CSEL_W = 3;
  localparam int SYNC_W = 5;
  localparam int FLT_W = 3;
  localparam int TICK_N = 7;
  localparam int SYNC_N = 31;

  localparam logic [ADDR_W-1:0] OFS_CON1 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CON2 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRI = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SEC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TMR = 8'h18;

  localparam int CON1_MODE_LSB = 0;
  localparam int CON1_TMODE_BIT = 3;
  localparam int CON1_CSEL_LSB = 10;
  localparam int CON1_FLT_LSB = 13;
  localparam int CON2_SYNC_LSB = 0;
  localparam int CON2_TRIS_BIT = 5;
  localparam int CON2_TRIG_BIT = 7;
  localparam int CON2_CASC_BIT = 8;
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;

  localparam logic [REG_W-1:0] CON1_RST = 16'h0000;
  localparam logic [REG_W-1:0] CON2_RST = 16'h0020;
  localparam logic [REG_W-1:0] CMP_RST = 16'h0000;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
  localparam logic [SYNC_W-1:0] SYNC_SELF = 5'h1f;
  localparam logic [CSEL_W-1:0] CSEL_SYS = 3'h7;

  typedef enum logic [MODE_W-1:0] {
    OCP_OFF, OCP_SGL_HI, OCP_SGL_LO, OCP_TOGGLE,
    OCP_DBL_ONE, OCP_DBL_CONT, OCP_PWM_EDGE, OCP_PWM_CTR
  } ocp_mode_t;

  function automatic logic is_pwm(input ocp_mode_t m);
    is_pwm = (m == OCP_PWM_EDGE) || (m == OCP_PWM_CTR);
  endfunction
endpackage

// file: shared/ocp_tb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ocp_tb_if #(parameter int W = 16);
  logic [W-1:0] count;
  logic tick;
  logic up;
  logic wrap;
  modport src(output count, output tick, output up, output wrap);
  modport dst(input count, input tick, input up, input wrap);
endinterface
`default_nettype wire

// file: rtl/ocp_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module ocp_timebase
  import ocp_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_center,
  input wire logic [CSEL_W-1:0] i_clk_sel,
  input wire logic [TICK_N-1:0] i_tmr_tick,
  input wire logic i_cascade,
  input wire logic i_casc_carry,
  input wire logic [SYNC_W-1:0] i_sync_sel,
  input wire logic [SYNC_N-1:0] i_sync_src,
  input wire logic i_trig_sel,
  input wire logic i_trig_mode,
  input wire logic [W-1:0] i_period,
  ocp_tb_if.src tb
);
  logic [W-1:0] count_r;
  logic up_r;
  logic armed_r;
  logic [TICK_N:0] srcs;
  logic [SYNC_N:0] syncs;
  logic ext;
  logic go;
  logic top;
  logic self_sync;

  assign srcs = {1'b1, i_tmr_tick};
  assign syncs = {i_sync_src, 1'b0};
  assign self_sync = i_sync_sel == SYNC_SELF;
  assign ext = !self_sync && syncs[i_sync_sel];
  assign go = !i_trig_sel || armed_r;
  assign top = count_r == i_period;
  // Odd half of a pair counts on the even half's carry
  assign tb.tick = i_run && go && (i_cascade ? i_casc_carry : srcs[i_clk_sel]);
  assign tb.count = count_r;
  assign tb.up = up_r;
  assign tb.wrap = i_run && (i_center ? (tb.tick && !up_r && count_r == '0)
                   : ((tb.tick && self_sync && top) || (!i_trig_sel && ext)));

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !i_run) begin
      armed_r <= 1'b0;
    end else if (i_trig_sel && ext) begin
      armed_r <= 1'b1;
    end else if (i_trig_mode && tb.wrap) begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !i_run) begin
      count_r <= '0;
      up_r <= 1'b1;
    end else if (!i_center && !i_trig_sel && ext) begin
      count_r <= '0;
    end else if (tb.tick) begin
      if (!i_center) begin
        count_r <= (self_sync && top) ? '0 : count_r + 1'b1;
      end else if (up_r) begin
        up_r <= !top;
        count_r <= top ? count_r - 1'b1 : count_r + 1'b1;
      end else begin
        up_r <= count_r == '0;
        count_r <= (count_r == '0) ? count_r + 1'b1 : count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/ocp_cmp_core.sv
`timescale 1ns/1ps
`default_nettype none
module ocp_cmp_core
  import ocp_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire ocp_mode_t i_mode,
  input wire logic i_arm,
  input wire logic i_fault,
  input wire logic [W-1:0] i_pri,
  input wire logic [W-1:0] i_sec,
  ocp_tb_if.dst tb,
  output logic o_out,
  output logic o_event,
  output logic o_armed
);
  logic pri_hit;
  logic sec_hit;
  logic done;

  assign pri_hit = tb.tick && tb.count == i_pri;
  assign sec_hit = tb.tick && tb.count == i_sec;
  assign done = o_armed && ((i_mode == OCP_DBL_ONE) ? sec_hit
               : ((i_mode == OCP_SGL_HI || i_mode == OCP_SGL_LO) && pri_hit));

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_armed <= 1'b0;
    end else if (i_arm) begin
      o_armed <= 1'b1;
    end else if (done) begin
      o_armed <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_out <= 1'b0;
    end else if (i_arm) begin
      o_out <= i_mode == OCP_SGL_LO;
    end else if (i_fault && is_pwm(i_mode)) begin
      o_out <= 1'b0;
    end else begin
      case (i_mode)
        OCP_SGL_HI: if (o_armed && pri_hit) o_out <= 1'b1;
        OCP_SGL_LO: if (o_armed && pri_hit) o_out <= 1'b0;
        OCP_TOGGLE: if (pri_hit) o_out <= !o_out;
        OCP_DBL_ONE, OCP_DBL_CONT: begin
          if (o_armed && sec_hit) o_out <= 1'b0;
          else if (o_armed && pri_hit) o_out <= 1'b1;
        end
        OCP_PWM_EDGE: begin
          if (tb.wrap) o_out <= i_pri != '0;
          else if (pri_hit) o_out <= 1'b0;
        end
        OCP_PWM_CTR: if (pri_hit) o_out <= tb.up;
        default: o_out <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_event <= 1'b0;
    end else begin
      case (i_mode)
        OCP_SGL_HI, OCP_SGL_LO: o_event <= o_armed && pri_hit;
        OCP_TOGGLE: o_event <= pri_hit;
        OCP_DBL_ONE, OCP_DBL_CONT: o_event <= o_armed && sec_hit;
        OCP_PWM_EDGE, OCP_PWM_CTR: o_event <= tb.wrap;
        default: o_event <= 1'b0;
      endcase
    end
  end

  pri_set_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_mode == OCP_SGL_HI && o_armed && pri_hit && !i_arm |=> o_out ##1 !o_armed || i_arm)
    else $error("primary match did not set output");
  dbl_back_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_mode == OCP_DBL_ONE || i_mode == OCP_DBL_CONT) && o_armed && sec_hit && !i_arm |=> !o_out)
    else $error("secondary match did not restore output");
  one_shot_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_mode == OCP_SGL_HI && !o_armed && !i_arm |=> $stable(o_out) && !o_event)
    else $error("single shot fired twice");
  ctr_fall_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_mode == OCP_PWM_CTR && pri_hit && !tb.up && !i_arm && !i_fault |=> !o_out)
    else $error("center pulse did not fall");
  dbl_flag_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_mode == OCP_DBL_CONT && o_armed && sec_hit |=> o_event ##1 !o_event || $past(sec_hit))
    else $error("secondary match raised no event");
endmodule
`default_nettype wire

// file: rtl/ocp_top.sv
`timescale 1ns/1ps
`default_nettype none
module ocp_top
  import ocp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [TICK_N-1:0] i_tmr_tick,
  input wire logic [SYNC_N-1:0] i_sync_src,
  input wire logic i_casc_carry,
  input wire logic [FLT_W-1:0] i_fault_pin,
  output logic o_carry,
  output logic o_cmp_out,
  output logic o_cmp_oe_n,
  output logic o_irq
);
  logic [REG_W-1:0] con1_r;
  logic [REG_W-1:0] con2_r;
  logic [CNT_W-1:0] pri_r;
  logic [CNT_W-1:0] sec_r;
  logic [CNT_W-1:0] pri_buf_r;
  logic [CNT_W-1:0] sec_buf_r;
  logic [CNT_W-1:0] pri_use;
  logic [CNT_W-1:0] sec_use;
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] stat_nxt;
  logic [STAT_W-1:0] mask_r;
  logic [FLT_W-1:0] flt_s1_r;
  logic [FLT_W-1:0] flt_s2_r;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] rd_nxt;
  logic irq_r;
  logic acc;
  logic wr;
  logic con1_wr;
  logic arm_r;
  logic core_ev;
  logic core_out;
  logic core_armed;
  logic fault_act;
  logic fault_hold;
  logic run;
  logic pwm;
  logic center;
  ocp_mode_t mode;

  ocp_tb_if #(.W(CNT_W)) tb ();

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = a inside {OFS_CON1, OFS_CON2, OFS_PRI, OFS_SEC,
                       OFS_STAT, OFS_MASK, OFS_TMR};
  endfunction

  // Byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] o,
                                             input logic [DATA_W-1:0] d,
                                             input logic [3:0] s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  assign mode = ocp_mode_t'(con1_r[CON1_MODE_LSB +: MODE_W]);
  assign run = mode != OCP_OFF;
  assign pwm = is_pwm(mode);
  assign center = mode == OCP_PWM_CTR;

  // APB slave, zero wait states
  assign acc = i_psel && i_penable;
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !mapped(i_paddr);
  assign wr = acc && i_pwrite && mapped(i_paddr);
  assign con1_wr = wr && i_paddr == OFS_CON1;
  assign o_prdata = prdata_r;

  always_comb begin
    rd_nxt = '0;
    case (i_paddr)
      OFS_CON1: rd_nxt = DATA_W'(con1_r);
      OFS_CON2: rd_nxt = DATA_W'(con2_r);
      OFS_PRI: rd_nxt = DATA_W'(pri_r);
      OFS_SEC: rd_nxt = DATA_W'(sec_r);
      OFS_STAT: rd_nxt = DATA_W'({core_armed, stat_r});
      OFS_MASK: rd_nxt = DATA_W'(mask_r);
      OFS_TMR: rd_nxt = DATA_W'(tb.count);
      default: rd_nxt = '0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      prdata_r <= '0;
    end else if (i_psel && !i_penable) begin
      prdata_r <= rd_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      con1_r <= CON1_RST;
      con2_r <= CON2_RST;
      pri_r <= CMP_RST;
      sec_r <= CMP_RST;
      mask_r <= MASK_RST;
    end else if (wr) begin
      case (i_paddr)
        OFS_CON1: con1_r <= merge(con1_r, i_pwdata, i_pstrb);
        OFS_CON2: con2_r <= merge(con2_r, i_pwdata, i_pstrb);
        OFS_PRI: pri_r <= merge(pri_r, i_pwdata, i_pstrb);
        OFS_SEC: sec_r <= merge(sec_r, i_pwdata, i_pstrb);
        OFS_MASK: if (i_pstrb[0]) mask_r <= i_pwdata[STAT_W-1:0];
        default: ;
      endcase
    end
  end

  // Shadow copies reload at a period boundary, and every cycle while the mode is off
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pri_buf_r <= CMP_RST;
      sec_buf_r <= CMP_RST;
    end else if (!run || tb.wrap) begin
      pri_buf_r <= pri_r;
      sec_buf_r <= sec_r;
    end
  end

  assign pri_use = pwm ? pri_buf_r : pri_r;
  assign sec_use = pwm ? sec_buf_r : sec_r;

  // Fault pins come from outside the clock domain
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      flt_s1_r <= '0;
      flt_s2_r <= '0;
    end else begin
      flt_s1_r <= i_fault_pin;
      flt_s2_r <= flt_s1_r;
    end
  end

  assign fault_act = |(flt_s2_r & con1_r[CON1_FLT_LSB +: FLT_W])
                     && mask_r[STAT_MATCH_BIT];
  // In PWM modes the output stays parked until software clears the flag
  assign fault_hold = fault_act || stat_r[STAT_FAULT_BIT];

  // Write one to clear; a new event wins over the clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr && i_paddr == OFS_STAT && i_pstrb[0]) begin
      stat_nxt = stat_r & ~i_pwdata[STAT_W-1:0];
    end
    if (core_ev) begin
      stat_nxt[STAT_MATCH_BIT] = 1'b1;
    end
    if (fault_act) begin
      stat_nxt[STAT_FAULT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // Arm one cycle after the control write, so the core sees the new mode
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      arm_r <= 1'b0;
    end else begin
      arm_r <= con1_wr;
    end
  end

  assign o_irq = irq_r;
  assign o_cmp_oe_n = con2_r[CON2_TRIS_BIT];
  assign o_carry = tb.wrap;
  assign o_cmp_out = core_out;

  ocp_timebase #(.W(CNT_W)) u_timebase (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_run(run),
    .i_center(center),
    .i_clk_sel(con1_r[CON1_CSEL_LSB +: CSEL_W]),
    .i_tmr_tick(i_tmr_tick),
    .i_cascade(con2_r[CON2_CASC_BIT]),
    .i_casc_carry(i_casc_carry),
    .i_sync_sel(con2_r[CON2_SYNC_LSB +: SYNC_W]),
    .i_sync_src(i_sync_src),
    .i_trig_sel(con2_r[CON2_TRIG_BIT]),
    .i_trig_mode(con1_r[CON1_TMODE_BIT]),
    .i_period(sec_use),
    .tb(tb)
  );

  ocp_cmp_core #(.W(CNT_W)) u_core (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_mode(mode),
    .i_arm(arm_r),
    .i_fault(fault_hold),
    .i_pri(pri_use),
    .i_sec(sec_use),
    .tb(tb),
    .o_out(core_out),
    .o_event(core_ev),
    .o_armed(core_armed)
  );

  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  unmapped_err_a: assert property (
    acc && !mapped(i_paddr) |-> o_pslverr && o_pready)
    else $error("unmapped access without error");

  tmr_read_a: assert property (
    i_psel && !i_penable && !i_pwrite && i_paddr == OFS_TMR
    |=> o_prdata == DATA_W'($past(tb.count)))
    else $error("timer read returned wrong value");

  flag_set_a: assert property (
    core_ev |=> stat_r[STAT_MATCH_BIT])
    else $error("match event did not set flag");

  set_wins_a: assert property (
    core_ev && wr && i_paddr == OFS_STAT && i_pstrb[0] && i_pwdata[STAT_MATCH_BIT]
    |=> stat_r[STAT_MATCH_BIT])
    else $error("clear beat a new event");

  irq_level_a: assert property (
    (stat_r & mask_r) != '0 |=> o_irq)
    else $error("interrupt not raised");

  buf_hold_a: assert property (
    run && pwm && !tb.wrap ##1 run && pwm
    |-> $stable(pri_buf_r) && $stable(sec_buf_r))
    else $error("shadow changed inside a period");

  self_sync_a: assert property (
    run && !center && con2_r[CON2_SYNC_LSB +: SYNC_W] == SYNC_SELF
    && tb.tick && tb.count == sec_use && !con1_wr |=> tb.count == '0)
    else $error("own period did not restart count");

  tick_gate_a: assert property (
    run && !con2_r[CON2_CASC_BIT] && con2_r[CON2_SYNC_LSB +: SYNC_W] == SYNC_SELF
    && con1_r[CON1_CSEL_LSB +: CSEL_W] != CSEL_SYS
    && !i_tmr_tick[con1_r[CON1_CSEL_LSB +: CSEL_W]] && !con1_wr
    |=> $stable(tb.count))
    else $error("count moved without source tick");

  fault_gate_a: assert property (
    !stat_r[STAT_FAULT_BIT] && !fault_act |=> !stat_r[STAT_FAULT_BIT])
    else $error("fault flag set with no enabled fault");

  fault_out_a: assert property (
    stat_r[STAT_FAULT_BIT] && pwm && !con1_wr |=> !o_cmp_out)
    else $error("output not parked on fault");

  irq_clear_a: assert property (
    (stat_r & mask_r) == '0 |=> !o_irq)
    else $error("interrupt raised with nothing pending");

  arm_low_a: assert property (
    arm_r && mode == OCP_SGL_LO |=> o_cmp_out)
    else $error("single low mode did not start high");
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin $display("MISMATCH %s expected %0h seen %0h", nm, e, g); fail_count++; end end
module testbench;
  import ocp_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} ocp_exp_t;
  logic clk;
  logic rst_n;
  logic psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [TICK_N-1:0] tick;
  logic [TICK_N-1:0] sel_mask;
  logic [SYNC_N-1:0] sync;
  logic casc, casc_on;
  logic [FLT_W-1:0] fpin;
  logic carry, cout, oe_n, irq;
  logic pout, pcar;
  int fail_count, n_checks;
  int rise_out, hi_out, rise_car, ph;
  int ro, hi, rc, pri;
  integer seed;
  ocp_exp_t exp_q[$];
  ocp_exp_t ex;

  ocp_top i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_tmr_tick(tick), .i_sync_src(sync),
    .i_casc_carry(casc), .i_fault_pin(fpin), .o_carry(carry), .o_cmp_out(cout),
    .o_cmp_oe_n(oe_n), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Unselected tick lines pulse every cycle, the selected one every third
  always @(posedge clk) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    tick <= (ph == 0) ? '1 : ~sel_mask;
    casc <= (ph == 0) && casc_on;
    pout <= cout;
    pcar <= carry;
    if (cout === 1'b1 && pout === 1'b0) rise_out <= rise_out + 1;
    if (cout === 1'b1) hi_out <= hi_out + 1;
    if (carry === 1'b1 && pcar === 1'b0) rise_car <= rise_car + 1;
  end

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      `CHECK("prdata", ex.d & ex.m, prdata & ex.m)
      `CHECK("pslverr", ex.e, pslverr)
    end
  end

  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    exp_q.push_back('{d, m, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    apb(1'b0, a, d, m, 1'b0);
  endtask

  task automatic meas(input int n);
    int a, b, c;
    @(posedge clk);
    a = rise_out;
    b = hi_out;
    c = rise_car;
    repeat (n) @(posedge clk);
    ro = rise_out - a;
    hi = hi_out - b;
    rc = rise_car - c;
  endtask

  task automatic go(input logic [31:0] con1, input int settle);
    wr(OFS_CON1, 32'h0);
    wr(OFS_STAT, 32'h3);
    wr(OFS_CON1, con1);
    repeat (settle) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end

  initial begin
    {rst_n, psel, penable, pwrite, casc_on, pout, pcar} = '0;
    {paddr, pwdata, sync, fpin, tick} = '0;
    pstrb = 4'hf;
    sel_mask = '1;
    {fail_count, n_checks, rise_out, hi_out, rise_car, ph} = '0;
    seed = 42822;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHECK("oe_n reset", 1'b1, oe_n)
    `CHECK("irq reset", 1'b0, irq)
    `CHECK("out reset", 1'b0, cout)
    rd(OFS_CON1, 32'h0, 32'hffffffff);
    rd(OFS_CON2, 32'h20, 32'hffffffff);
    rd(OFS_PRI, 32'h0, 32'hffffffff);
    rd(OFS_SEC, 32'h0, 32'hffffffff);
    rd(OFS_MASK, 32'h0, 32'hffffffff);
    apb(1'b0, 8'h1c, 32'h0, 32'hffffffff, 1'b1);
    wr(OFS_TMR, 32'h5);
    rd(OFS_TMR, 32'h0, 32'hffff);
    pri = 1 + ($unsigned($random(seed)) % 4);
    wr(OFS_PRI, 32'(pri));
    wr(OFS_SEC, 32'h5);
    wr(OFS_CON2, 32'h1f);
    @(negedge clk);
    `CHECK("oe_n driven", 1'b0, oe_n)
    go(32'h1c06, 12);
    meas(48);
    `CHECK("edge pwm high", 8 * (pri + 1), hi)
    `CHECK("edge pwm wraps", 8, rc)
    go(32'h1c07, 20);
    meas(40);
    `CHECK("center pwm pulses", 4, ro)
    `CHECK("center pwm wraps", 4, rc)
    for (int s = 0; s < 7; s++) begin
      sel_mask <= TICK_N'(1 << s);
      go(32'h0006 | (32'(s) << 10), 40);
      meas(72);
      `CHECK("tick source wraps", 4, rc)
    end
    sel_mask <= '1;
    casc_on <= 1'b1;
    wr(OFS_CON2, 32'h11f);
    go(32'h1c06, 40);
    meas(72);
    `CHECK("cascade wraps", 4, rc)
    casc_on <= 1'b0;
    wr(OFS_CON2, 32'h1f);
    wr(OFS_PRI, 32'h2);
    go(32'h1c05, 12);
    meas(48);
    `CHECK("double cont pulses", 8, ro)
    `CHECK("double cont high", 24, hi)
    for (int r = 0; r < 2; r++) begin
      go(32'h1c04, 0);
      meas(60);
      `CHECK("double single shot", 1, ro)
      rd(OFS_STAT, 32'h1, 32'h1);
    end
    go(32'h1c01, 0);
    meas(60);
    `CHECK("single high", 1, ro)
    `CHECK("single high level", 1'b1, cout)
    go(32'h1c02, 0);
    @(posedge clk);
    @(negedge clk);
    `CHECK("single low start", 1'b1, cout)
    meas(60);
    `CHECK("single low end", 1'b0, cout)
    rd(OFS_STAT, 32'h1, 32'h1);
    go(32'h1c03, 12);
    meas(48);
    `CHECK("toggle pulses", 4, ro)
    wr(OFS_CON2, 32'h83);
    go(32'h1c05, 0);
    meas(30);
    `CHECK("trigger held", 0, ro)
    sync <= SYNC_N'(1 << 2);
    @(posedge clk);
    sync <= '0;
    meas(48);
    `CHECK("trigger run", 1, ro)
    `CHECK("trigger pulse high", 3, hi)
    wr(OFS_CON2, 32'h1f);
    wr(OFS_MASK, 32'h0);
    go(32'h1c06, 20);
    `CHECK("irq masked", 1'b0, irq)
    wr(OFS_MASK, 32'h1);
    repeat (4) @(posedge clk);
    `CHECK("irq raised", 1'b1, irq)
    go(32'h0, 4);
    `CHECK("irq cleared", 1'b0, irq)
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CON1, 32'h1c06 | (32'h1 << (13 + k)));
      fpin <= FLT_W'(1 << ((k + 1) % 3));
      repeat (12) @(posedge clk);
      meas(48);
      `CHECK("fault disabled", 24, hi)
      fpin <= FLT_W'((1 << k) | (1 << ((k + 1) % 3)));
      repeat (6) @(posedge clk);
      meas(24);
      `CHECK("fault forced low", 0, hi)
      rd(OFS_STAT, 32'h2, 32'h2);
      fpin <= '0;
      wr(OFS_STAT, 32'h2);
      repeat (12) @(posedge clk);
      meas(48);
      `CHECK("fault recovered", 24, hi)
    end
    final_report();
  end
endmodule
`default_nettype wire
